// [hdl/drp_ctrl.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [R01] Debugger powers a component's valid power domain before accessing it.
// [R02] Debugger withdraws power request when unused or state save protects it.
// [R03] System power request to domain mapping is fixed and not reported.
// [R04] Debug reset request and acknowledge registers cover up to 32 domains.
// [R05] System reset request and acknowledge registers cover up to 32 domains.
// [R06] Debugger follows every debug reset handshake step in order.
// [R07] System held in reset while system reset request bit is one.
// [R08] Debug logic reset during system reset is released immediately after.
// [R09] Clearing the request bit by any reset releases the system reset.
// [R10] Debugger follows every system reset handshake step in order.
// [R11] Power requests ignored while all debug functions are disabled.
// [R12] With security split, reset requests need secure invasive debug enabled.
// [R13] Without security split, reset requests need invasive debug enabled.
// [R14] Without security split, secure and non-secure status fields match.
// [R15] Secure non-invasive status field in bits 7:6, upper bits zero.
// [R16] Secure invasive status field in bits 5:4.
// [R17] Non-secure non-invasive status field in bits 3:2.
// [R18] Non-secure invasive status field in bits 1:0.
// [R19] Four identification words return fixed bytes 0d, 90, 05, b1.
// [R20] Claim tag registers read zero and ignore writes.
// [R21] Up to 32 debug power domains each with a control register.
// [R22] Bit 1 is the power request, bits 31:2 read zero.
// [R23] Writing one requests power, writing zero withdraws it.
// [R24] Bit 0 is a fixed present flag; absent domains ignore requests.
// [R25] Aligned word accesses; reserved offsets and bits read zero.
module drp_ctrl #(
    parameter int          N_DBG_PWR      = 32,
    parameter int          N_SYS_PWR      = 32,
    parameter int          N_DBG_RST      = 32,
    parameter int          N_SYS_RST      = 32,
    parameter logic [31:0] DBG_PWR_PRESENT = 32'hffff_ffff,
    parameter logic [31:0] SYS_PWR_PRESENT = 32'hffff_ffff,
    parameter bit          SECURE_SPLIT   = 1'b1
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic [11:0]         s_awaddr,
    input  wire logic                s_awvalid,
    output logic                     s_awready,
    input  wire logic [31:0]         s_wdata,
    input  wire logic [3:0]          s_wstrb,
    input  wire logic                s_wvalid,
    output logic                     s_wready,
    output logic [1:0]               s_bresp,
    output logic                     s_bvalid,
    input  wire logic                s_bready,
    input  wire logic [11:0]         s_araddr,
    input  wire logic                s_arvalid,
    output logic                     s_arready,
    output logic [31:0]              s_rdata,
    output logic [1:0]               s_rresp,
    output logic                     s_rvalid,
    input  wire logic                s_rready,
    input  wire drp_pkg::drp_auth_s  auth_pins,
    input  wire logic [31:0]         dbg_rst_done,
    input  wire logic [31:0]         sys_rst_done,
    output logic [31:0]              dbg_pwr_req,
    output logic [31:0]              sys_pwr_req,
    output logic [31:0]              dbg_rst_req,
    output logic [31:0]              sys_rst_hold
);
    import drp_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    drp_auth_s   auth_m;
    drp_auth_s   auth;
    logic [31:0] dack_m;
    logic [31:0] dack;
    logic [31:0] sack_m;
    logic [31:0] sack;

    always_ff @(posedge mclk) begin
        if (rst) begin
            auth_m <= '0;
            auth   <= '0;
            dack_m <= RST_VAL_ZERO;
            dack   <= RST_VAL_ZERO;
            sack_m <= RST_VAL_ZERO;
            sack   <= RST_VAL_ZERO;
        end else begin
            auth_m <= auth_pins;
            auth   <= auth_m;
            dack_m <= dbg_rst_done;
            dack   <= dack_m;
            sack_m <= sys_rst_done;
            sack   <= sack_m;
        end
    end

    // ------------------------------------------------------------
    // Authentication
    // ------------------------------------------------------------
    logic        any_debug_en;
    logic        rst_allowed;
    logic [31:0] auth_word;
    logic        secure_noninvasive_status_on;
    logic        sid_on;
    logic        nonsecure_noninvasive_status_on;
    logic        nonsecure_invasive_status_on;

    assign nonsecure_invasive_status_on  = auth.invasive_enable;
    assign nonsecure_noninvasive_status_on = auth.noninvasive_enable | auth.invasive_enable;
    // Without a split both secure fields mirror the non-secure ones
    assign secure_noninvasive_status_on  = SECURE_SPLIT ? ((auth.secure_invasive_enable
                      | auth.secure_noninvasive_enable) & nonsecure_noninvasive_status_on) : nonsecure_noninvasive_status_on; // [R14] [R15]
    assign sid_on   = SECURE_SPLIT ? (auth.secure_invasive_enable
                      & auth.invasive_enable) : nonsecure_invasive_status_on; // [R14] [R16]
    assign auth_word = {24'h00_0000,
                        secure_noninvasive_status_on ? AUTH_ENABLED : AUTH_DISABLED,
                        sid_on ? AUTH_ENABLED : AUTH_DISABLED,
                        nonsecure_noninvasive_status_on ? AUTH_ENABLED : AUTH_DISABLED, // [R17]
                        nonsecure_invasive_status_on ? AUTH_ENABLED : AUTH_DISABLED}; // [R18]
    assign any_debug_en = secure_noninvasive_status_on | nonsecure_noninvasive_status_on; // [R11]
    assign rst_allowed  = SECURE_SPLIT ? sid_on : nonsecure_invasive_status_on; // [R12] [R13]

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;

    assign wr_go = aw_held & w_held & ~s_bvalid;

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held   <= 1'b0;
            aw_addr   <= 12'h000;
            s_awready <= 1'b0;
        end else begin
            s_awready <= ~aw_held & ~(s_awvalid & s_awready);
            if (s_awvalid & s_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            w_held   <= 1'b0;
            w_data   <= RST_VAL_ZERO;
            w_strb   <= 4'h0;
            s_wready <= 1'b0;
        end else begin
            s_wready <= ~w_held & ~(s_wvalid & s_wready);
            if (s_wvalid & s_wready) begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp  <= RESP_OKAY; // [R25]
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic        wr_full;
    logic [4:0]  wr_idx;
    logic        hit_dpc;
    logic        hit_spc;

    assign wr_full = wr_go & (w_strb[0] == 1'b1) & (aw_addr[1:0] == 2'b00);
    assign wr_idx  = aw_addr[6:2];
    assign hit_dpc = aw_addr[11:7] == OFS_DBG_PWR_CTRL[11:7];
    assign hit_spc = aw_addr[11:7] == OFS_SYS_PWR_CTRL[11:7];

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_dom
            always_ff @(posedge mclk) begin
                if (rst) begin
                    dbg_pwr_req[g] <= 1'b0;
                end else if (g >= N_DBG_PWR || !DBG_PWR_PRESENT[g]) begin
                    dbg_pwr_req[g] <= 1'b0; // [R21] [R24]
                end else if (wr_full && hit_dpc && wr_idx == 5'(g) && any_debug_en) begin
                    dbg_pwr_req[g] <= w_data[POS_PWR_REQ]; // [R22] [R23] [R11]
                end
            end
            always_ff @(posedge mclk) begin
                if (rst) begin
                    sys_pwr_req[g] <= 1'b0;
                end else if (g >= N_SYS_PWR || !SYS_PWR_PRESENT[g]) begin
                    sys_pwr_req[g] <= 1'b0;
                end else if (wr_full && hit_spc && wr_idx == 5'(g) && any_debug_en) begin
                    sys_pwr_req[g] <= w_data[POS_PWR_REQ]; // [R03] [R11]
                end
            end
        end
    endgenerate

    logic [31:0] dbg_mask;
    logic [31:0] sys_mask;
    assign dbg_mask = (N_DBG_RST >= 32) ? 32'hffff_ffff : 32'((64'h1 << N_DBG_RST) - 64'h1);
    assign sys_mask = (N_SYS_RST >= 32) ? 32'hffff_ffff : 32'((64'h1 << N_SYS_RST) - 64'h1);

    // Requests hold until software writes zero; a reset clears them
    always_ff @(posedge mclk) begin
        if (rst) begin
            dbg_rst_req <= RST_VAL_ZERO;
        end else if (wr_full && aw_addr == OFS_DBG_RST_REQ && rst_allowed) begin
            dbg_rst_req <= w_data & dbg_mask; // [R04] [R12] [R13]
        end
    end

    // The hold output is the request bit itself, so clearing it releases
    always_ff @(posedge mclk) begin
        if (rst) begin
            sys_rst_hold <= RST_VAL_ZERO; // [R09]
        end else if (wr_full && aw_addr == OFS_SYS_RST_REQ && rst_allowed) begin
            sys_rst_hold <= w_data & sys_mask; // [R05] [R07] [R12] [R13]
        end
    end
    // Debug logic in this block never enters reset from a system reset request [R08]

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic [4:0]  rd_idx;

    assign rd_idx = s_araddr[6:2];

    always_comb begin
        next_rdata = RST_VAL_ZERO; // [R25]
        if (s_araddr[11:7] == OFS_DBG_PWR_CTRL[11:7]) begin
            next_rdata[POS_PWR_PRESENT] = (32'(rd_idx) < N_DBG_PWR) & DBG_PWR_PRESENT[rd_idx];
            next_rdata[POS_PWR_REQ]     = dbg_pwr_req[rd_idx]; // [R22]
        end else if (s_araddr[11:7] == OFS_SYS_PWR_CTRL[11:7]) begin
            next_rdata[POS_PWR_PRESENT] = (32'(rd_idx) < N_SYS_PWR) & SYS_PWR_PRESENT[rd_idx];
            next_rdata[POS_PWR_REQ]     = sys_pwr_req[rd_idx];
        end else begin
            unique case (s_araddr)
                OFS_DBG_RST_REQ: next_rdata = dbg_rst_req;
                OFS_DBG_RST_ACK: next_rdata = dack & dbg_mask;
                OFS_SYS_RST_REQ: next_rdata = sys_rst_hold;
                OFS_SYS_RST_ACK: next_rdata = sack & sys_mask;
                OFS_CLAIM_SET:   next_rdata = RST_VAL_ZERO; // [R20]
                OFS_CLAIM_CLR:   next_rdata = RST_VAL_ZERO; // [R20]
                OFS_AUTH_STATUS: next_rdata = auth_word;
                OFS_COMP_ID0:    next_rdata = {24'h00_0000, COMP_ID0_VAL}; // [R19]
                OFS_COMP_ID1:    next_rdata = {24'h00_0000, COMP_ID1_VAL}; // [R19]
                OFS_COMP_ID2:    next_rdata = {24'h00_0000, COMP_ID2_VAL}; // [R19]
                OFS_COMP_ID3:    next_rdata = {24'h00_0000, COMP_ID3_VAL}; // [R19]
                default:         next_rdata = RST_VAL_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= RST_VAL_ZERO;
            s_rresp   <= RESP_OKAY;
        end else begin
            s_arready <= ~s_rvalid & ~(s_arvalid & s_arready);
            if (s_arvalid & s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata  <= next_rdata;
                s_rresp  <= RESP_OKAY;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_auth_fields: assert property (@(posedge mclk) disable iff (rst)
        auth_word[31:8] == 24'h0 && auth_word[1] && auth_word[3] && auth_word[5] && auth_word[7])
        else $error("status fields malformed"); // [R15]
    a_nonsecure_invasive_status_follow: assert property (@(posedge mclk) disable iff (rst)
        auth_word[0] == auth.invasive_enable) else $error("nonsecure_invasive_status wrong"); // [R18]
    a_nonsecure_noninvasive_status_follow: assert property (@(posedge mclk) disable iff (rst)
        auth_word[2] == (auth.invasive_enable | auth.noninvasive_enable))
        else $error("nonsecure_noninvasive_status wrong"); // [R17]
    a_sid_follow: assert property (@(posedge mclk) disable iff (rst)
        SECURE_SPLIT |-> auth_word[4] == (auth.invasive_enable & auth.secure_invasive_enable))
        else $error("sid wrong"); // [R16]
    a_split_mirror: assert property (@(posedge mclk) disable iff (rst)
        !SECURE_SPLIT |-> auth_word[7:6] == auth_word[3:2] && auth_word[5:4] == auth_word[1:0])
        else $error("fields differ"); // [R14]
    a_rst_gated: assert property (@(posedge mclk) disable iff (rst)
        !rst_allowed |=> $stable(sys_rst_hold) && $stable(dbg_rst_req))
        else $error("reset request taken while disabled"); // [R12]
    a_pwr_gated: assert property (@(posedge mclk) disable iff (rst)
        !any_debug_en && !$past(rst) |=> $stable(dbg_pwr_req))
        else $error("power request taken while disabled"); // [R11]
    a_pwr_write: assert property (@(posedge mclk) disable iff (rst)
        wr_full && hit_dpc && wr_idx == 5'd0 && any_debug_en && DBG_PWR_PRESENT[0]
        |=> dbg_pwr_req[0] == $past(w_data[1])) else $error("power write lost"); // [R23]
    a_sys_hold: assert property (@(posedge mclk) disable iff (rst)
        wr_full && aw_addr == OFS_SYS_RST_REQ && rst_allowed && w_data[0]
        |=> sys_rst_hold[0] [*2]) else $error("system not held"); // [R07]
    a_id_read: assert property (@(posedge mclk) disable iff (rst)
        s_arvalid && s_arready && s_araddr == OFS_COMP_ID3 |=> s_rdata == 32'h0000_00b1)
        else $error("id read wrong"); // [R19]
    a_claim_zero: assert property (@(posedge mclk) disable iff (rst)
        s_arvalid && s_arready && s_araddr == OFS_CLAIM_SET |=> s_rdata == 32'h0)
        else $error("claim nonzero"); // [R20]
    a_b_after: assert property (@(posedge mclk) disable iff (rst)
        wr_go |=> s_bvalid) else $error("no write response"); // [R25]

    // ------------------------------------------------------------
    // Register and bus checks
    // ------------------------------------------------------------
    // Reset must beat any request write landing in the same cycle
    a_hold_release: assert property (@(posedge mclk) // [R09]
        rst |=> sys_rst_hold == RST_VAL_ZERO && dbg_rst_req == RST_VAL_ZERO)
        else $error("requests survive reset");
    a_dbg_rst_write: assert property (@(posedge mclk) disable iff (rst) // [R04]
        wr_full && aw_addr == OFS_DBG_RST_REQ && rst_allowed
        |=> dbg_rst_req == ($past(w_data) & dbg_mask))
        else $error("debug reset request lost");
    a_sys_rst_write: assert property (@(posedge mclk) disable iff (rst) // [R05]
        wr_full && aw_addr == OFS_SYS_RST_REQ && rst_allowed
        |=> sys_rst_hold == ($past(w_data) & sys_mask))
        else $error("system reset request lost");
    a_sys_pwr_write: assert property (@(posedge mclk) disable iff (rst) // [R03]
        wr_full && hit_spc && wr_idx == 5'd31 && any_debug_en && SYS_PWR_PRESENT[31]
        |=> sys_pwr_req[31] == $past(w_data[1]))
        else $error("system power write lost");
    a_absent_domain: assert property (@(posedge mclk) disable iff (rst) // [R24]
        (dbg_pwr_req & ~DBG_PWR_PRESENT) == RST_VAL_ZERO
        && (sys_pwr_req & ~SYS_PWR_PRESENT) == RST_VAL_ZERO)
        else $error("absent domain requested");
    a_sys_pwr_gated: assert property (@(posedge mclk) disable iff (rst) // [R11]
        !any_debug_en && !$past(rst) |=> $stable(sys_pwr_req))
        else $error("system power taken while disabled");
    a_read_resp: assert property (@(posedge mclk) disable iff (rst) // [R25]
        s_rvalid |-> s_rresp == RESP_OKAY)
        else $error("read response not okay");
    a_write_resp: assert property (@(posedge mclk) disable iff (rst) // [R25]
        s_bvalid |-> s_bresp == RESP_OKAY)
        else $error("write response not okay");
    a_r_after: assert property (@(posedge mclk) disable iff (rst) // [R25]
        s_arvalid && s_arready |=> s_rvalid)
        else $error("no read response");
    a_id0_read: assert property (@(posedge mclk) disable iff (rst) // [R19]
        s_arvalid && s_arready && s_araddr == OFS_COMP_ID0 |=> s_rdata == 32'h0000_000d)
        else $error("first id read wrong");
    a_claim_clr: assert property (@(posedge mclk) disable iff (rst) // [R20]
        s_arvalid && s_arready && s_araddr == OFS_CLAIM_CLR |=> s_rdata == 32'h0)
        else $error("claim clear nonzero");
    a_auth_read: assert property (@(posedge mclk) disable iff (rst) // [R15]
        s_arvalid && s_arready && s_araddr == OFS_AUTH_STATUS |=> s_rdata[31:8] == 24'h0)
        else $error("status upper bits set");
    a_pwr_read_hi: assert property (@(posedge mclk) disable iff (rst) // [R22]
        s_arvalid && s_arready && s_araddr[11:7] == OFS_DBG_PWR_CTRL[11:7]
        |=> s_rdata[31:2] == 30'h0)
        else $error("power control upper bits set");
endmodule

// [pkg/drp_pkg.sv]
package drp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_DBG_PWR_CTRL = 12'ha00;
    localparam logic [11:0] OFS_SYS_PWR_CTRL = 12'hb00;
    localparam logic [11:0] OFS_DBG_RST_REQ  = 12'hc10;
    localparam logic [11:0] OFS_DBG_RST_ACK  = 12'hc14;
    localparam logic [11:0] OFS_SYS_RST_REQ  = 12'hc18;
    localparam logic [11:0] OFS_SYS_RST_ACK  = 12'hc1c;
    localparam logic [11:0] OFS_CLAIM_SET    = 12'hfa0;
    localparam logic [11:0] OFS_CLAIM_CLR    = 12'hfa4;
    localparam logic [11:0] OFS_AUTH_STATUS  = 12'hfb8;
    localparam logic [11:0] OFS_COMP_ID0     = 12'hff0;
    localparam logic [11:0] OFS_COMP_ID1     = 12'hff4;
    localparam logic [11:0] OFS_COMP_ID2     = 12'hff8;
    localparam logic [11:0] OFS_COMP_ID3     = 12'hffc;
    // ------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------
    localparam int          POS_PWR_PRESENT  = 0;
    localparam int          POS_PWR_REQ      = 1;
    localparam int          POS_RST_REQ      = 0;
    localparam logic [7:0]  COMP_ID0_VAL     = 8'h0d;
    localparam logic [7:0]  COMP_ID1_VAL     = 8'h90;
    localparam logic [7:0]  COMP_ID2_VAL     = 8'h05;
    localparam logic [7:0]  COMP_ID3_VAL     = 8'hb1;
    localparam logic [1:0]  AUTH_ENABLED     = 2'b11;
    localparam logic [1:0]  AUTH_DISABLED    = 2'b10;
    localparam logic [1:0]  AUTH_UNSUPP      = 2'b00;
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;
    localparam logic [31:0] RST_VAL_ZERO     = 32'h0000_0000;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic invasive_enable;
        logic noninvasive_enable;
        logic secure_invasive_enable;
        logic secure_noninvasive_enable;
    } drp_auth_s;
endpackage

// [dv/drp_rst_partner.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Reset controller model: acknowledges after a short or long delay
// ------------------------------------------------------------
module drp_rst_partner (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic [31:0] dbg_rst_req,
    input  wire logic [31:0] sys_rst_hold,
    output logic [31:0]      dbg_rst_done,
    output logic [31:0]      sys_rst_done
);
    logic [31:0] dbg_pipe [12];
    logic [31:0] sys_pipe [12];

    always_ff @(posedge mclk) begin
        dbg_pipe[0] <= dbg_rst_req;
        sys_pipe[0] <= sys_rst_hold;
        for (int i = 1; i < 12; i++) begin
            dbg_pipe[i] <= dbg_pipe[i-1] & dbg_rst_req;
            sys_pipe[i] <= sys_pipe[i-1] & sys_rst_hold;
        end
    end

    // Ack drops with the request, so a stale ack never outlives it
    assign dbg_rst_done = (slow ? dbg_pipe[11] : dbg_pipe[0]) & dbg_rst_req;
    assign sys_rst_done = (slow ? sys_pipe[11] : sys_pipe[0]) & sys_rst_hold;
endmodule

// [dv/drp_ctrl_tb.sv]
`timescale 1ns/1ps
module drp_ctrl_tb;
    import drp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        mclk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd, d;
    logic [3:0]  s_wstrb = 4'hf;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    drp_auth_s   auth_pins = '0;
    logic [31:0] dbg_rst_done, sys_rst_done, dbg_pwr_req, sys_pwr_req, dbg_rst_req, sys_rst_hold;
    logic [7:0]  ids [4] = '{COMP_ID0_VAL, COMP_ID1_VAL, COMP_ID2_VAL, COMP_ID3_VAL};
    logic [11:0] a;
    int          num_errors = 0, comparisons = 0, seed = 33111, n;

    always #12.5 mclk = ~mclk;

    drp_ctrl dut (.mclk(mclk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .auth_pins(auth_pins),
        .dbg_rst_done(dbg_rst_done), .sys_rst_done(sys_rst_done), .dbg_pwr_req(dbg_pwr_req),
        .sys_pwr_req(sys_pwr_req), .dbg_rst_req(dbg_rst_req), .sys_rst_hold(sys_rst_hold));
    drp_rst_partner partner (.mclk(mclk), .slow(slow), .dbg_rst_req(dbg_rst_req),
        .sys_rst_hold(sys_rst_hold), .dbg_rst_done(dbg_rst_done), .sys_rst_done(sys_rst_done));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data);
        bit got;
        got = 0;
        s_awaddr  <= addr;
        s_wdata   <= data;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge mclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) got = 1;
        end
        check("bresp", {30'h0, s_bresp}, {30'h0, RESP_OKAY});
        if (!got) begin
            num_errors++;
            end_sim();
        end
    endtask

    task automatic axi_read(input logic [11:0] addr, output logic [31:0] data);
        bit got;
        got = 0;
        s_araddr  <= addr;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge mclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) got = 1;
        end
        data = s_rdata;
        if (!got) begin
            num_errors++;
            end_sim();
        end
    endtask

    // Synchronisers need two edges before a new level counts; the task waits three
    task automatic set_auth(input logic [3:0] v);
        auth_pins <= drp_auth_s'(v);
        repeat (3) @(posedge mclk);
    endtask

    task automatic wait_ack(input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] v;
        v = ~exp;
        for (int i = 0; i < 40 && v !== exp; i++) axi_read(addr, v);
        check("reset_ack", v, exp);
        if (v !== exp) end_sim();
    endtask

    function automatic logic [1:0] lvl(input logic b);
        return b ? AUTH_ENABLED : AUTH_DISABLED;
    endfunction

    function automatic logic [31:0] exp_auth(input logic [3:0] p);
        return {24'h0, lvl((p[1] | p[0]) & (p[3] | p[2])), lvl(p[1] & p[3]),
                lvl(p[2] | p[3]), lvl(p[3])};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            axi_read(OFS_COMP_ID0 + 12'(4 * i), rd);
            check("comp_id", rd, {24'h0, ids[i]});
        end
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? OFS_CLAIM_SET : (i == 1) ? OFS_CLAIM_CLR : (i == 2) ? 12'h800 : 12'hc04;
            axi_write(a, $random(seed) | 32'h1);
            axi_read(a, rd);
            check("claim_or_reserved", rd, 32'h0);
        end
        for (int i = 0; i < 16; i++) begin
            set_auth(4'(i));
            axi_read(OFS_AUTH_STATUS, rd);
            check("auth_status", rd, exp_auth(4'(i)));
        end
        set_auth(4'hf);
        for (int k = 0; k < 10; k++) begin
            n = (k < 2) ? 31 * k : ($random(seed) & 31);
            a = (k[0] ? OFS_SYS_PWR_CTRL : OFS_DBG_PWR_CTRL) + 12'(4 * n);
            d = $random(seed);
            axi_write(a, d | 32'h2);
            check("pwr_req_on", k[0] ? sys_pwr_req : dbg_pwr_req, 32'h1 << n);
            axi_read(a, rd);
            check("pwr_ctrl_read", rd, 32'h3);
            axi_write(a, d & ~32'h2);
            check("pwr_req_off", k[0] ? sys_pwr_req : dbg_pwr_req, 32'h0);
        end
        set_auth(4'h0);
        axi_write(OFS_DBG_PWR_CTRL + 12'h014, 32'h2);
        check("pwr_gated", dbg_pwr_req, 32'h0);
        set_auth(4'b0100);
        axi_write(OFS_DBG_PWR_CTRL + 12'h014, 32'h2);
        check("pwr_noninv", dbg_pwr_req, 32'h20);
        axi_write(OFS_DBG_PWR_CTRL + 12'h014, 32'h0);
        axi_write(OFS_SYS_RST_REQ, 32'hffff_ffff);
        axi_write(OFS_DBG_RST_REQ, 32'hffff_ffff);
        check("rst_gated", sys_rst_hold | dbg_rst_req, 32'h0);
        set_auth(4'hf);
        for (int k = 0; k < 4; k++) begin
            a = k[0] ? OFS_SYS_RST_REQ : OFS_DBG_RST_REQ;
            slow <= k[1];
            d = $random(seed) | 32'h1;
            axi_write(a, d);
            check("rst_req_on", k[0] ? sys_rst_hold : dbg_rst_req, d);
            wait_ack(a + 12'h4, d);
            axi_write(a, 32'h0);
            check("rst_req_off", k[0] ? sys_rst_hold : dbg_rst_req, 32'h0);
            wait_ack(a + 12'h4, 32'h0);
        end
        axi_write(OFS_SYS_RST_REQ, 32'hffff_ffff);
        check("hold_set", sys_rst_hold, 32'hffff_ffff);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        check("hold_cleared", sys_rst_hold, 32'h0);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        axi_read(OFS_SYS_RST_REQ, rd);
        check("req_after_reset", rd, 32'h0);
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        end_sim();
    end
endmodule
